// File: tacr_pkg.sv
// Constants and types shared by the thermal agent configuration bank
`default_nettype none

package tacr_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned AGENTS = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TEMP_W = 16;
  localparam int unsigned BASE_W = 7;
  localparam int unsigned TADDR_W = 7;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_AGENT_CFG = 8'he0;
  localparam logic [7:0] OFS_AGENT1_TEMP_BASE = 8'he1;
  localparam logic [7:0] OFS_AGENT2_TEMP_BASE = 8'he2;
  localparam logic [7:0] OFS_AGENT3_TEMP_BASE = 8'he3;
  localparam logic [7:0] OFS_AGENT4_TEMP_BASE = 8'he4;
  localparam logic [7:0] OFS_AGENT_DOMAIN_CONFIG = 8'he5;
  localparam logic [7:0] OFS_AGENT4_REL_TEMP_LOW = 8'he6;
  localparam logic [7:0] OFS_AGENT4_REL_TEMP_HIGH = 8'he7;
  localparam logic [7:0] OFS_WARN_FLAG = 8'he8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [6:0] BASE_RST = 7'h48;
  localparam logic [7:0] DOMAIN_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [3:0] RTD_RST = 4'h0;
  localparam logic [3:0] EN_RST = 4'h0;
  localparam logic [3:0] PRESENT_RST = 4'h0;
  localparam logic RET_HIGH_RST = 1'b0;
  localparam logic BANK_RST = 1'b0;
  localparam logic [15:0] TEMP_RST = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CFG_RTD_LSB = 0;
  localparam int unsigned CFG_EN_LSB = 4;
  localparam int unsigned DOM_RET_HIGH_BIT = 1;
  localparam int unsigned DOM_PRESENT_LSB = 4;
  localparam int unsigned FLAG_BANK_BIT = 3;
  localparam int unsigned FLAG_AGENT_LSB = 4;
  localparam int unsigned BASE_RSVD_BIT = 7;

  // ****************************************************************
  // Thermal-bus target addresses
  // ****************************************************************
  localparam logic [6:0] TARGET_ADDR_FIRST = 7'h30;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tacr_bus_s;

  typedef struct packed {
    logic ret_high;
    logic present;
    logic rtd;
  } tacr_rsel_s;

  typedef enum logic [1:0] {
    TACR_SRC_NONE,
    TACR_SRC_CFG,
    TACR_SRC_TEMP
  } tacr_src_e;

endpackage : tacr_pkg

`default_nettype wire

// File: tacr_dom_sel.sv
// Per-agent domain selection of the reported relative temperature
`default_nettype none

module tacr_dom_sel (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [15:0] dom0_temp_in,
  input wire logic [15:0] dom1_temp_in,
  input wire tacr_pkg::tacr_rsel_s sel_in,
  output logic [15:0] temp_out
);

  // ****************************************************************
  // Selection
  // ****************************************************************
  logic [15:0] temp_nxt;
  logic d1_higher;

  // Relative temperatures are two's complement, so compare signed
  assign d1_higher = $signed(dom1_temp_in) > $signed(dom0_temp_in);

  always_comb begin
    temp_nxt = dom0_temp_in;
    if (sel_in.present) begin
      if (sel_in.ret_high) begin
        temp_nxt = d1_higher ? dom1_temp_in : dom0_temp_in;
      end else if (sel_in.rtd) begin
        temp_nxt = dom1_temp_in;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      temp_out <= tacr_pkg::TEMP_RST;
    end else begin
      temp_out <= temp_nxt;
    end
  end

endmodule : tacr_dom_sel

`default_nettype wire

// File: tacr_regs.sv
// Thermal agent configuration register bank with relative temperature bank
`default_nettype none

module tacr_regs (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire tacr_pkg::tacr_bus_s bus_in,
  output logic [7:0] rdata_out,
  input wire logic [3:0][15:0] dom0_temp_in,
  input wire logic [3:0][15:0] dom1_temp_in,
  input wire logic [3:0] alert_in,
  input wire logic [3:0] absent_in,
  output logic [3:0][15:0] agent_temp_out,
  output logic [3:0][6:0] temp_base_out,
  output logic [3:0] agent_enable_out,
  output logic [3:0] second_domain_present_out,
  output logic return_high_out,
  output logic bank_select_out,
  output logic [3:0][6:0] target_addr_out
);

  // ****************************************************************
  // Address decode helpers
  // ****************************************************************

  // Index of an agent base register, valid with is_base
  function automatic logic [1:0] base_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - tacr_pkg::OFS_AGENT1_TEMP_BASE;
    return diff[1:0];
  endfunction

  function automatic logic is_base(input logic [7:0] addr);
    return (addr >= tacr_pkg::OFS_AGENT1_TEMP_BASE) &&
           (addr <= tacr_pkg::OFS_AGENT4_TEMP_BASE);
  endfunction

  // Temperature window spans config through agent 4 high byte
  function automatic logic is_temp_window(input logic [7:0] addr);
    return (addr >= tacr_pkg::OFS_AGENT_CFG) &&
           (addr <= tacr_pkg::OFS_AGENT4_REL_TEMP_HIGH);
  endfunction

  // Byte of the temperature window: agent in bits 2..1, high in bit 0
  function automatic logic [2:0] temp_slot(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - tacr_pkg::OFS_AGENT_CFG;
    return diff[2:0];
  endfunction

  function automatic logic [7:0] temp_byte(
    input logic [3:0][15:0] temps,
    input logic [2:0] slot
  );
    logic [15:0] word;
    word = temps[slot[2:1]];
    return slot[0] ? word[15:8] : word[7:0];
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [6:0] base_r [4];
  logic [3:0] rtd_r;
  logic [3:0] enable_r;
  logic [3:0] present_r;
  logic ret_high_r;
  logic bank_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [3:0][15:0] sel_temp;

  // ****************************************************************
  // Base registers
  // ****************************************************************

  // Bit 7 is not stored, so it reads zero and ignores writes
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 4; i++) begin
        base_r[i] <= tacr_pkg::BASE_RST;
      end
    end else if (bus_in.wr && is_base(bus_in.addr)) begin
      // Sign is not checked: a negative base is the software's fault
      base_r[base_index(bus_in.addr)] <= bus_in.wdata[6:0];
    end
  end

  // ****************************************************************
  // Agent configuration register
  // ****************************************************************

  // Writes reach the stored value whatever the bank view
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rtd_r <= tacr_pkg::RTD_RST;
      enable_r <= tacr_pkg::EN_RST;
    end else if (bus_in.wr && bus_in.addr == tacr_pkg::OFS_AGENT_CFG) begin
      rtd_r <= bus_in.wdata[tacr_pkg::CFG_RTD_LSB +: 4];
      enable_r <= bus_in.wdata[tacr_pkg::CFG_EN_LSB +: 4];
    end
  end

  // ****************************************************************
  // Domain register
  // ****************************************************************
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      present_r <= tacr_pkg::PRESENT_RST;
      ret_high_r <= tacr_pkg::RET_HIGH_RST;
    end else if (bus_in.wr &&
                 bus_in.addr == tacr_pkg::OFS_AGENT_DOMAIN_CONFIG) begin
      present_r <= bus_in.wdata[tacr_pkg::DOM_PRESENT_LSB +: 4];
      ret_high_r <= bus_in.wdata[tacr_pkg::DOM_RET_HIGH_BIT];
    end
  end

  // ****************************************************************
  // Bank select in the warning-flag register
  // ****************************************************************

  // Only the bank bit is kept here; flags come from the bus engine
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bank_r <= tacr_pkg::BANK_RST;
    end else if (bus_in.wr && bus_in.addr == tacr_pkg::OFS_WARN_FLAG) begin
      bank_r <= bus_in.wdata[tacr_pkg::FLAG_BANK_BIT];
    end
  end

  // ****************************************************************
  // Reported temperature per agent
  // ****************************************************************
  for (genvar g = 0; g < 4; g++) begin : g_agent
    tacr_pkg::tacr_rsel_s rsel;

    assign rsel.ret_high = ret_high_r;
    assign rsel.present = present_r[g];
    assign rsel.rtd = rtd_r[g];

    tacr_dom_sel u_dom_sel (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .dom0_temp_in(dom0_temp_in[g]),
      .dom1_temp_in(dom1_temp_in[g]),
      .sel_in(rsel),
      .temp_out(sel_temp[g])
    );

    // Agent g answers at the first target address plus g
    assign target_addr_out[g] =
      tacr_pkg::TARGET_ADDR_FIRST + 7'(g);
    assign temp_base_out[g] = base_r[g];
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************

  // Configuration view of one mapped offset
  function automatic logic [7:0] cfg_byte(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (is_base(addr)) begin
      v[6:0] = base_r[base_index(addr)];
    end else if (addr == tacr_pkg::OFS_AGENT_CFG) begin
      v[tacr_pkg::CFG_RTD_LSB +: 4] = rtd_r;
      v[tacr_pkg::CFG_EN_LSB +: 4] = enable_r;
    end else if (addr == tacr_pkg::OFS_AGENT_DOMAIN_CONFIG) begin
      v[tacr_pkg::DOM_PRESENT_LSB +: 4] = present_r;
      v[tacr_pkg::DOM_RET_HIGH_BIT] = ret_high_r;
    end
    return v;
  endfunction

  function automatic tacr_pkg::tacr_src_e read_src(
    input logic [7:0] addr,
    input logic bank
  );
    tacr_pkg::tacr_src_e s;
    s = tacr_pkg::TACR_SRC_NONE;
    if (addr == tacr_pkg::OFS_AGENT4_REL_TEMP_LOW ||
        addr == tacr_pkg::OFS_AGENT4_REL_TEMP_HIGH) begin
      // Read-only pair answers in either view
      s = tacr_pkg::TACR_SRC_TEMP;
    end else if (is_temp_window(addr)) begin
      s = bank ? tacr_pkg::TACR_SRC_TEMP : tacr_pkg::TACR_SRC_CFG;
    end
    return s;
  endfunction

  always_comb begin
    rdata_nxt = 8'h00;
    if (bus_in.rd) begin
      if (bus_in.addr == tacr_pkg::OFS_WARN_FLAG) begin
        rdata_nxt[tacr_pkg::FLAG_BANK_BIT] = bank_r;
        rdata_nxt[tacr_pkg::FLAG_AGENT_LSB +: 4] =
          bank_r ? absent_in : alert_in;
      end else begin
        unique case (read_src(bus_in.addr, bank_r))
          tacr_pkg::TACR_SRC_NONE: begin
            rdata_nxt = 8'h00;
          end
          tacr_pkg::TACR_SRC_CFG: begin
            rdata_nxt = cfg_byte(bus_in.addr);
          end
          tacr_pkg::TACR_SRC_TEMP: begin
            // Slot 1 is agent 1 high, 2/3 agent 2, 4/5 agent 3
            rdata_nxt = temp_byte(sel_temp,
                                  temp_slot(bus_in.addr));
          end
          default: begin
            rdata_nxt = 8'h00;
          end
        endcase
      end
    end
  end

  // Data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_out = rdata_r;
  assign agent_temp_out = sel_temp;
  assign agent_enable_out = enable_r;
  assign second_domain_present_out = present_r;
  assign return_high_out = ret_high_r;
  assign bank_select_out = bank_r;

endmodule : tacr_regs

`default_nettype wire

// File: tacr_regs_checker.sv
// Port-level assertions for the thermal agent configuration bank
`default_nettype none

module tacr_regs_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire tacr_pkg::tacr_bus_s bus_in,
  input wire logic [7:0] rdata_out,
  input wire logic [3:0][15:0] dom0_temp_in,
  input wire logic [3:0][15:0] dom1_temp_in,
  input wire logic [3:0][15:0] agent_temp_out,
  input wire logic [3:0][6:0] temp_base_out,
  input wire logic [3:0] second_domain_present_out,
  input wire logic return_high_out,
  input wire logic bank_select_out,
  input wire logic [3:0][6:0] target_addr_out
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_rdata_idle_zero: assert property (
    !$past(bus_in.rd) |-> rdata_out == 8'h00) else $error("rdata not idle");
  chk_base_write: assert property (
    bus_in.wr && bus_in.addr == 8'he1
    |=> temp_base_out[0] == $past(bus_in.wdata[6:0]))
    else $error("base write lost");
  chk_base_read: assert property (
    bus_in.rd && bus_in.addr == 8'he1 && !bank_select_out
    |=> rdata_out == {1'b0, $past(temp_base_out[0])})
    else $error("base read wrong");
  chk_bank_agent1_hi: assert property (
    bus_in.rd && bus_in.addr == 8'he1 && bank_select_out
    |=> rdata_out == $past(agent_temp_out[0][15:8]))
    else $error("agent1 high byte wrong");
  chk_bank_agent2_hi: assert property (
    bus_in.rd && bus_in.addr == 8'he3 && bank_select_out
    |=> rdata_out == $past(agent_temp_out[1][15:8]))
    else $error("agent2 high byte wrong");
  chk_bank_agent3_hi: assert property (
    bus_in.rd && bus_in.addr == 8'he5 && bank_select_out
    |=> rdata_out == $past(agent_temp_out[2][15:8]))
    else $error("agent3 high byte wrong");
  chk_agent4_hi: assert property (
    bus_in.rd && bus_in.addr == 8'he7
    |=> rdata_out == $past(agent_temp_out[3][15:8]))
    else $error("agent4 high byte wrong");
  chk_domain_write: assert property (
    bus_in.wr && bus_in.addr == 8'he5
    |=> second_domain_present_out == $past(bus_in.wdata[7:4])
    && return_high_out == $past(bus_in.wdata[1]))
    else $error("domain write lost");
  chk_single_domain: assert property (
    !second_domain_present_out[0]
    |=> agent_temp_out[0] == $past(dom0_temp_in[0]))
    else $error("absent domain used");
  // Signed compare: a cold domain is negative
  chk_return_high: assert property (
    second_domain_present_out[0] && return_high_out
    |=> agent_temp_out[0] == (($signed($past(dom1_temp_in[0])) >
    $signed($past(dom0_temp_in[0]))) ? $past(dom1_temp_in[0])
    : $past(dom0_temp_in[0]))) else $error("highest not returned");
  chk_target_addr: assert property (
    target_addr_out[0] == 7'h30 && target_addr_out[3] == 7'h33)
    else $error("target address wrong");

  cover property (bus_in.rd && bank_select_out && bus_in.addr == 8'he1);
  cover property (second_domain_present_out[0] && return_high_out);
  cover property (bus_in.wr && bus_in.addr == 8'he5);
endmodule // tacr_regs_checker

bind tacr_regs tacr_regs_checker tacr_regs_checker_i (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus_in),
  .rdata_out(rdata_out), .dom0_temp_in(dom0_temp_in),
  .dom1_temp_in(dom1_temp_in), .agent_temp_out(agent_temp_out),
  .temp_base_out(temp_base_out),
  .second_domain_present_out(second_domain_present_out),
  .return_high_out(return_high_out), .bank_select_out(bank_select_out),
  .target_addr_out(target_addr_out)
);

`default_nettype wire

// File: tb_tacr_regs.sv
// Self-checking bench for the thermal agent configuration bank
`default_nettype none

module tb_tacr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  tacr_pkg::tacr_bus_s bus_in = '0;
  logic [7:0] rdata_out;
  // Negative domain 0 catches an unsigned max; agent 4 domain 0 is higher
  logic [3:0][15:0] dom0_temp_in = {16'h0505, 16'h8003, 16'h8002, 16'h8001};
  logic [3:0][15:0] dom1_temp_in = {16'h0404, 16'h0303, 16'h0202, 16'h0101};
  logic [3:0] alert_in = 4'ha;
  logic [3:0] absent_in = 4'h5;
  logic [3:0][15:0] agent_temp_out, exp_t;
  logic [3:0][6:0] temp_base_out, target_addr_out;
  logic [3:0] agent_enable_out, second_domain_present_out;
  logic return_high_out, bank_select_out;
  logic [15:0] cfg [4] = '{16'h000f, 16'hf005, 16'hf200, 16'h5200};
  int fails = 0;
  int n_tests = 0;

  tacr_regs tacr_regs_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .dom0_temp_in(dom0_temp_in),
    .dom1_temp_in(dom1_temp_in), .alert_in(alert_in),
    .absent_in(absent_in), .agent_temp_out(agent_temp_out),
    .temp_base_out(temp_base_out), .agent_enable_out(agent_enable_out),
    .second_domain_present_out(second_domain_present_out),
    .return_high_out(return_high_out), .bank_select_out(bank_select_out),
    .target_addr_out(target_addr_out)
  );

  initial forever #10 clk_in = ~clk_in;

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_in.addr <= a;
    bus_in.wdata <= d;
    bus_in.wr <= 1'b1;
    @(posedge clk_in);
    bus_in.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    bus_in.addr <= a;
    bus_in.rd <= 1'b1;
    @(posedge clk_in);
    bus_in.rd <= 1'b0;
    #1;
    cmp({8'h00, rdata_out}, {8'h00, e});
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (logic [7:0] a = 8'he1; a < 8'he5; a++) begin
      rdc(a, 8'h48);
    end
    rdc(8'he5, 8'h00);
    rdc(8'he8, 8'ha0);
    for (int i = 0; i < 4; i++) begin
      cmp({9'h000, target_addr_out[i]}, 16'(16'h0030 + i));
    end
    $display("reset test done");
    wr(8'he1, 8'hbf);
    rdc(8'he1, 8'h3f);
    cmp({9'h000, temp_base_out[0]}, 16'h003f);
    wr(8'he5, 8'hff);
    rdc(8'he5, 8'hf2);
    wr(8'he6, 8'h55);
    wr(8'h10, 8'h55);
    rdc(8'h10, 8'h00);
    $display("write test done");
    for (int k = 0; k < 4; k++) begin
      wr(8'he5, cfg[k][15:8]);
      wr(8'he0, cfg[k][7:0]);
      rdc(8'he0, cfg[k][7:0]);
      cmp({12'h000, agent_enable_out}, {12'h000, cfg[k][7:4]});
      cmp({11'h000, second_domain_present_out, return_high_out},
          {11'h000, cfg[k][15:12], cfg[k][9]});
      for (int i = 0; i < 4; i++) begin
        if (cfg[k][12 + i] && cfg[k][9]) begin
          exp_t[i] = ($signed(dom1_temp_in[i]) > $signed(dom0_temp_in[i]))
            ? dom1_temp_in[i] : dom0_temp_in[i];
        end else if (cfg[k][12 + i] && cfg[k][i]) begin
          exp_t[i] = dom1_temp_in[i];
        end else begin
          exp_t[i] = dom0_temp_in[i];
        end
      end
      repeat (2) @(posedge clk_in);
      #1;
      for (int i = 0; i < 4; i++) begin
        cmp(agent_temp_out[i], exp_t[i]);
      end
    end
    $display("domain test done");
    wr(8'he8, 8'hff);
    rdc(8'he8, 8'h58);
    cmp({15'h0000, bank_select_out}, 16'h0001);
    for (logic [7:0] a = 8'he0; a < 8'he8; a++) begin
      rdc(a, exp_t[a[2:1]][8 * a[0] +: 8]);
    end
    wr(8'he8, 8'h00);
    rdc(8'he8, 8'ha0);
    rdc(8'he1, 8'h3f);
    $display("bank test done");
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rdc(8'he1, 8'h48);
    rdc(8'he5, 8'h00);
    $display("second reset test done");
    conclude();
  end

  // Whole sequence needs well under 200 cycles
  initial begin
    #100us;
    fails++;
    conclude();
  end
endmodule // tb_tacr_regs

`default_nettype wire
